// File: hdl/mcg_top.sv
// AXI4-Lite register bank for computation mode and channel gain control
//
// The implementer's own choice: the AXI4-Lite register port.
`include "mcg_regs.svh"

module mcg_top #(
	parameter bit NEUTRAL_PRESENT = 1'b1
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`MCG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`MCG_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output mcg_pkg::mcg_angle_t         angle_measure_mode_q,
	output logic                        phase_a_nominal_voltage_enable_q,
	output logic                        phase_b_nominal_voltage_enable_q,
	output logic                        phase_c_nominal_voltage_enable_q,
	output logic                        line_frequency_select_q,
	output logic [2:0]                  phase_current_gain_q,
	output logic [2:0]                  neutral_current_gain_q,
	output logic [2:0]                  phase_voltage_gain_q
);

	// Without a neutral channel its gain field is never stored
	localparam logic [15:0] GAIN_MASK = NEUTRAL_PRESENT ?
		`MCG_GAIN_MASK : `MCG_GAIN_MASK_NN;

	// Write channel state
	mcg_pkg::mcg_wr_state_t  wr_state_q;
	mcg_pkg::mcg_wr_state_t  wr_state_d;
	mcg_pkg::mcg_rd_state_t  rd_state_q;
	logic                    aw_have_q;
	logic                    aw_have_d;
	logic                    w_have_q;
	logic                    w_have_d;
	// Captured write payload
	logic [`MCG_ADDR_W-1:0]  waddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic [15:0]             comp_q;
	logic [15:0]             gain_q;
	logic [15:0]             wr_merge;
	logic [15:0]             wr_old;
	logic                    wr_hit_comp;
	logic                    wr_hit_gain;
	logic                    aw_fire;
	logic                    w_fire;
	logic [15:0]             rd_val;
	logic                    rd_hit;
	// Per-channel gain codes before and after the reserved fallback
	logic [2:0]              gain_raw   [3];
	logic [2:0]              gain_apply [3];
	mcg_pkg::mcg_angle_t     angle_mode;

	// Only exact word addresses decode; anything else answers SLVERR
	assign aw_fire     = s_axi_awvalid && s_axi_awready;
	assign w_fire      = s_axi_wvalid && s_axi_wready;
	assign wr_hit_comp = (waddr_q == `MCG_COMP_ADDR);
	assign wr_hit_gain = (waddr_q == `MCG_GAIN_ADDR);

	// Address and data may arrive in either order; each is latched once
	always_comb begin
		aw_have_d  = aw_have_q || aw_fire;
		w_have_d   = w_have_q || w_fire;
		wr_state_d = wr_state_q;
		case (wr_state_q)
			mcg_pkg::MCG_WR_COLLECT: begin
				if (aw_have_d && w_have_d) begin
					wr_state_d = mcg_pkg::MCG_WR_APPLY;
				end
			end
			mcg_pkg::MCG_WR_APPLY: begin
				aw_have_d  = 1'b0;
				w_have_d   = 1'b0;
				wr_state_d = mcg_pkg::MCG_WR_RESP;
			end
			mcg_pkg::MCG_WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_d = mcg_pkg::MCG_WR_COLLECT;
				end
			end
			default: begin
				aw_have_d  = 1'b0;
				w_have_d   = 1'b0;
				wr_state_d = mcg_pkg::MCG_WR_COLLECT;
			end
		endcase
	end

	// Readies stay low from a transfer until its response is accepted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q    <= mcg_pkg::MCG_WR_COLLECT;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			wr_state_q    <= wr_state_d;
			aw_have_q     <= aw_have_d;
			w_have_q      <= w_have_d;
			s_axi_awready <= (wr_state_d == mcg_pkg::MCG_WR_COLLECT) &&
				!aw_have_d;
			s_axi_wready  <= (wr_state_d == mcg_pkg::MCG_WR_COLLECT) &&
				!w_have_d;
		end
	end

	// Address and data wait here for the apply cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_fire) begin
				waddr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Byte lanes 2 and 3 land on bits that do not exist and are dropped
	always_comb begin
		wr_old   = wr_hit_comp ? comp_q : gain_q;
		wr_merge = wr_old;
		if (wstrb_q[0]) begin
			wr_merge[7:0] = wdata_q[7:0];
		end
		if (wstrb_q[1]) begin
			wr_merge[15:8] = wdata_q[15:8];
		end
	end

	// Bit 15 is kept as written but steers nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_q <= `MCG_COMP_RESET;
		end else if (wr_state_q == mcg_pkg::MCG_WR_APPLY && wr_hit_comp) begin
			comp_q <= wr_merge;
		end
	end

	// Reserved bits and an absent neutral field are masked on entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gain_q <= `MCG_GAIN_RESET;
		end else if (wr_state_q == mcg_pkg::MCG_WR_APPLY && wr_hit_gain) begin
			gain_q <= wr_merge & GAIN_MASK;
		end
	end

	// Unmapped writes change nothing and answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `MCG_RESP_OKAY;
		end else if (wr_state_q == mcg_pkg::MCG_WR_APPLY) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_hit_comp || wr_hit_gain) ?
				`MCG_RESP_OKAY : `MCG_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux follows the address; sampled only at the AR handshake
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 16'h0000;
		if (s_axi_araddr == `MCG_COMP_ADDR) begin
			rd_val = comp_q;
		end else if (s_axi_araddr == `MCG_GAIN_ADDR) begin
			rd_val = gain_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// One read in flight; address is refused until the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q    <= mcg_pkg::MCG_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `MCG_RESP_OKAY;
		end else begin
			case (rd_state_q)
				mcg_pkg::MCG_RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						rd_state_q    <= mcg_pkg::MCG_RD_DATA;
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= {16'h0000, rd_val};
						s_axi_rresp   <= rd_hit ?
							`MCG_RESP_OKAY : `MCG_RESP_SLVERR;
					end
				end
				mcg_pkg::MCG_RD_DATA: begin
					if (s_axi_rready) begin
						rd_state_q    <= mcg_pkg::MCG_RD_IDLE;
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
					end
				end
				default: begin
					rd_state_q    <= mcg_pkg::MCG_RD_IDLE;
					s_axi_arready <= 1'b0;
					s_axi_rvalid  <= 1'b0;
				end
			endcase
		end
	end

	// One raw field per channel: current, neutral, voltage
	assign gain_raw[0] = gain_q[`MCG_PI_LSB +: 3];
	assign gain_raw[1] = gain_q[`MCG_NI_LSB +: 3];
	assign gain_raw[2] = gain_q[`MCG_PV_LSB +: 3];

	// Same fallback for all three channels
	for (genvar g = 0; g < 3; g++) begin : g_gain
		mcg_gain_decode u_dec (
			.code    (gain_raw[g]),
			.applied (gain_apply[g])
		);
	end

	// One-hot mode so the datapath needs no second decode
	mcg_angle_decode u_angle (
		.sel  (comp_q[`MCG_ANGLE_MSB:`MCG_ANGLE_LSB]),
		.mode (angle_mode)
	);

	// Registered controls cost one cycle but keep glitches off the datapath
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_current_gain_q   <= 3'h0;
			neutral_current_gain_q <= 3'h0;
			phase_voltage_gain_q   <= 3'h0;
		end else begin
			phase_current_gain_q   <= gain_apply[0];
			neutral_current_gain_q <= gain_apply[1];
			phase_voltage_gain_q   <= gain_apply[2];
		end
	end

	// Reset mode matches the reset code 00 of the field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			angle_measure_mode_q <= mcg_pkg::MCG_ANG_VI;
		end else begin
			angle_measure_mode_q <= angle_mode;
		end
	end

	// Substitution enables reach the datapath one cycle after the register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_a_nominal_voltage_enable_q <= 1'b0;
			phase_b_nominal_voltage_enable_q <= 1'b0;
			phase_c_nominal_voltage_enable_q <= 1'b0;
			line_frequency_select_q          <= 1'b0;
		end else begin
			phase_a_nominal_voltage_enable_q <= comp_q[`MCG_NOM_A_BIT];
			phase_b_nominal_voltage_enable_q <= comp_q[`MCG_NOM_B_BIT];
			phase_c_nominal_voltage_enable_q <= comp_q[`MCG_NOM_C_BIT];
			line_frequency_select_q          <= comp_q[`MCG_FREQ_BIT];
		end
	end

endmodule // mcg_top

// File: include/mcg_regs.svh
// Register map, field positions and reset values of the metering config bank
`ifndef MCG_REGS_SVH
`define MCG_REGS_SVH

`define MCG_ADDR_W        20
`define MCG_COMP_IDX      16'hE60E
`define MCG_GAIN_IDX      16'hE60F
`define MCG_COMP_ADDR     {2'h0, `MCG_COMP_IDX, 2'h0}
`define MCG_GAIN_ADDR     {2'h0, `MCG_GAIN_IDX, 2'h0}

`define MCG_COMP_RESET    16'h01FF
`define MCG_GAIN_RESET    16'h0000
`define MCG_GAIN_MASK     16'h01FF
`define MCG_GAIN_MASK_NN  16'h01C7

`define MCG_ANGLE_LSB     9
`define MCG_ANGLE_MSB     10
`define MCG_NOM_A_BIT     11
`define MCG_NOM_B_BIT     12
`define MCG_NOM_C_BIT     13
`define MCG_FREQ_BIT      14

`define MCG_PI_LSB        0
`define MCG_NI_LSB        3
`define MCG_PV_LSB        6
`define MCG_GAIN_MAX      3'h4

`define MCG_RESP_OKAY     2'h0
`define MCG_RESP_SLVERR   2'h2

`endif

// File: include/mcg_pkg.sv
// Types shared by the metering configuration bank
package mcg_pkg;

	typedef enum logic [3:0] {
		MCG_ANG_VI   = 4'h1,
		MCG_ANG_VV   = 4'h2,
		MCG_ANG_II   = 4'h4,
		MCG_ANG_NONE = 4'h8
	} mcg_angle_t;

	typedef enum logic [2:0] {
		MCG_WR_COLLECT = 3'h1,
		MCG_WR_APPLY   = 3'h2,
		MCG_WR_RESP    = 3'h4
	} mcg_wr_state_t;

	typedef enum logic [1:0] {
		MCG_RD_IDLE = 2'h1,
		MCG_RD_DATA = 2'h2
	} mcg_rd_state_t;

endpackage

// File: hdl/mcg_gain_decode.sv
// Maps a raw gain code to the gain actually applied (gain = 2 ** code)
`include "mcg_regs.svh"

module mcg_gain_decode (
	input  wire logic [2:0] code,
	output logic      [2:0] applied
);

	// Reserved codes fall back to unity gain rather than saturating
	always_comb begin
		if (code > `MCG_GAIN_MAX) begin
			applied = 3'h0;
		end else begin
			applied = code;
		end
	end

endmodule // mcg_gain_decode

// File: hdl/mcg_angle_decode.sv
// Maps the two-bit angle field to a one-hot measurement mode
module mcg_angle_decode (
	input  wire logic [1:0]        sel,
	output mcg_pkg::mcg_angle_t    mode
);

	always_comb begin
		case (sel)
			2'h0: begin
				mode = mcg_pkg::MCG_ANG_VI;
			end
			2'h1: begin
				mode = mcg_pkg::MCG_ANG_VV;
			end
			2'h2: begin
				mode = mcg_pkg::MCG_ANG_II;
			end
			default: begin
				mode = mcg_pkg::MCG_ANG_NONE;
			end
		endcase
	end

endmodule // mcg_angle_decode

// File: tb/mcg_top_props.sv
// Concurrent checks on the metering configuration bank ports
`include "mcg_regs.svh"
module mcg_top_chk (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic [`MCG_ADDR_W-1:0] s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_bvalid,
	input mcg_pkg::mcg_angle_t         angle_measure_mode_q,
	input wire logic                   phase_a_nominal_voltage_enable_q,
	input wire logic                   phase_b_nominal_voltage_enable_q,
	input wire logic                   phase_c_nominal_voltage_enable_q,
	input wire logic                   line_frequency_select_q,
	input wire logic [2:0]             phase_current_gain_q,
	input wire logic [2:0]             neutral_current_gain_q,
	input wire logic [2:0]             phase_voltage_gain_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [`MCG_ADDR_W-1:0] ar_q;
	logic                   rok;
	logic                   gok;
	logic                   cok;
	logic [3:0]             nom;
	logic [8:0]             gns;
	function automatic logic [2:0] dec(input logic [2:0] c);
		return (c <= 3'h4) ? c : 3'h0;
	endfunction
	// Address of the read in flight; reads are compared only with no write
	// under way, since outputs lag a write by two cycles
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ar_q <= 20'h00000;
		else if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	assign rok = s_axi_rvalid && s_axi_awready && s_axi_rresp == `MCG_RESP_OKAY;
	assign gok = rok && ar_q == `MCG_GAIN_ADDR;
	assign cok = rok && ar_q == `MCG_COMP_ADDR;
	assign nom = {line_frequency_select_q, phase_c_nominal_voltage_enable_q,
		phase_b_nominal_voltage_enable_q, phase_a_nominal_voltage_enable_q};
	assign gns = {phase_voltage_gain_q, neutral_current_gain_q,
		phase_current_gain_q};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pi; gok |-> phase_current_gain_q == dec(s_axi_rdata[2:0]);
	endproperty
	a_pi: assert property (p_pi) else $error("phase current gain wrong");
	property p_ni; gok |-> neutral_current_gain_q == dec(s_axi_rdata[5:3]);
	endproperty
	a_ni: assert property (p_ni) else $error("neutral gain wrong");
	property p_pv; gok |-> phase_voltage_gain_q == dec(s_axi_rdata[8:6]);
	endproperty
	a_pv: assert property (p_pv) else $error("voltage gain wrong");
	property p_gres; gok |-> s_axi_rdata[15:9] == 7'h00; endproperty
	a_gres: assert property (p_gres) else $error("gain spare bits set");
	property p_ang; cok |-> angle_measure_mode_q == 4'h1 << s_axi_rdata[10:9];
	endproperty
	a_ang: assert property (p_ang) else $error("angle mode wrong");
	property p_nom; cok |-> nom == s_axi_rdata[14:11]; endproperty
	a_nom: assert property (p_nom) else $error("nominal enables wrong");
	property p_upd; $changed(gns) || $changed(nom) ||
		$changed(angle_measure_mode_q) |-> $past(s_axi_bvalid);
	endproperty
	a_upd: assert property (p_upd) else $error("control moved unasked");
	property p_rst; $rose(aresetn) |-> angle_measure_mode_q == 4'h1
		&& gns == 9'h000 && nom == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset controls wrong");
endmodule // mcg_top_chk

bind mcg_top mcg_top_chk mcg_top_chk_i (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_awready, .s_axi_bvalid, .angle_measure_mode_q,
	.phase_a_nominal_voltage_enable_q, .phase_b_nominal_voltage_enable_q,
	.phase_c_nominal_voltage_enable_q, .line_frequency_select_q,
	.phase_current_gain_q, .neutral_current_gain_q, .phase_voltage_gain_q);

// File: tb/tb_mcg_top.sv
// Self-checking bench for the metering configuration bank
`include "mcg_regs.svh"
module tb_mcg_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                aclk, aresetn, s_axi_awvalid, s_axi_awready;
	logic                s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [19:0]         s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	mcg_pkg::mcg_angle_t angle_measure_mode_q;
	logic                phase_a_nominal_voltage_enable_q, line_frequency_select_q;
	logic                phase_b_nominal_voltage_enable_q;
	logic                phase_c_nominal_voltage_enable_q;
	logic [2:0]          phase_current_gain_q, neutral_current_gain_q;
	logic [2:0]          phase_voltage_gain_q;
	logic [31:0]         nn_rdata;
	logic [2:0]          nn_neutral_gain;
	logic [15:0]         v;
	logic [2:0]          c;
	int                  error_cnt, n_checks;

	mcg_top mcg_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.angle_measure_mode_q, .phase_a_nominal_voltage_enable_q,
		.phase_b_nominal_voltage_enable_q, .phase_c_nominal_voltage_enable_q,
		.line_frequency_select_q, .phase_current_gain_q, .neutral_current_gain_q,
		.phase_voltage_gain_q);

	// Same bus drives a bank built for variants without a neutral channel
	mcg_top #(.NEUTRAL_PRESENT(1'b0)) mcg_top_nn_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready(), .s_axi_rdata(nn_rdata), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready, .angle_measure_mode_q(),
		.phase_a_nominal_voltage_enable_q(),
		.phase_b_nominal_voltage_enable_q(),
		.phase_c_nominal_voltage_enable_q(), .line_frequency_select_q(),
		.phase_current_gain_q(), .neutral_current_gain_q(nn_neutral_gain),
		.phase_voltage_gain_q());

	function automatic logic [2:0] dec(input logic [2:0] k);
		return (k <= 3'h4) ? k : 3'h0;
	endfunction

	task automatic close_out;
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Address and data go out together; each is dropped once taken
	task automatic wrc(input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] er);
		logic aw, w, b;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				b = 1'b1;
				s_axi_bready <= 1'b0;
				chk("bresp", 32'(er), 32'(s_axi_bresp));
			end
		end
		// Decoded controls land one edge after the response
		@(posedge aclk);
	endtask

	task automatic rdc(input logic [19:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic b;
		logic [31:0] en;
		b = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				b = 1'b1;
				s_axi_rready <= 1'b0;
				chk("rdata", e, s_axi_rdata);
				chk("rresp", 32'(er), 32'(s_axi_rresp));
				en = (a == `MCG_GAIN_ADDR) ? e & {16'h0000, `MCG_GAIN_MASK_NN} : e;
				chk("rdata no neutral", en, nn_rdata);
			end
		end
	endtask

	task automatic outs(input logic [3:0] ang, input logic [3:0] nm,
		input logic [8:0] gn);
		chk("angle", 32'(ang), 32'(angle_measure_mode_q));
		chk("nominal", 32'(nm), 32'({line_frequency_select_q,
			phase_c_nominal_voltage_enable_q, phase_b_nominal_voltage_enable_q,
			phase_a_nominal_voltage_enable_q}));
		chk("gains", 32'(gn), 32'({phase_voltage_gain_q, neutral_current_gain_q,
			phase_current_gain_q}));
		chk("gain no neutral", 32'h00000000, 32'(nn_neutral_gain));
	endtask

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// About 40 bus operations of under ten cycles each
	initial begin
		#(5000 * 100);
		error_cnt++;
		close_out;
	end

	initial begin
		aresetn <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		s_axi_awaddr <= 20'h00000;
		s_axi_araddr <= 20'h00000;
		s_axi_wdata <= 32'h00000000;
		s_axi_wstrb <= 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`MCG_COMP_ADDR, 32'h000001FF, `MCG_RESP_OKAY);
		rdc(`MCG_GAIN_ADDR, 32'h00000000, `MCG_RESP_OKAY);
		outs(4'h1, 4'h0, 9'h000);
		for (int i = 0; i < 8; i++) begin
			v = {i[0], i[1], i[2:0], i[1:0], 9'h1FF};
			wrc(`MCG_COMP_ADDR, v, `MCG_RESP_OKAY);
			outs(4'h1 << i[1:0], {i[1], i[2:0]}, 9'h000);
			rdc(`MCG_COMP_ADDR, {16'h0000, v}, `MCG_RESP_OKAY);
		end
		// Spare bits written as ones to show they are dropped
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			v = {7'h7F, c, c + 3'h1, c + 3'h2};
			wrc(`MCG_GAIN_ADDR, v, `MCG_RESP_OKAY);
			outs(4'h8, 4'hF, {dec(c), dec(c + 3'h1), dec(c + 3'h2)});
			rdc(`MCG_GAIN_ADDR, {23'h000000, v[8:0]}, `MCG_RESP_OKAY);
		end
		wrc(20'h00000, 16'hFFFF, `MCG_RESP_SLVERR);
		rdc(20'h00000, 32'h00000000, `MCG_RESP_SLVERR);
		rdc(`MCG_GAIN_ADDR, 32'h000001C1, `MCG_RESP_OKAY);
		outs(4'h8, 4'hF, 9'h001);
		// Reset in mid-run must bring every register back to its reset value
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`MCG_COMP_ADDR, 32'h000001FF, `MCG_RESP_OKAY);
		rdc(`MCG_GAIN_ADDR, 32'h00000000, `MCG_RESP_OKAY);
		outs(4'h1, 4'h0, 9'h000);
		close_out;
	end
endmodule // tb_mcg_top
